// [bank_selector_block.sv]
// parameter bank selector with prioritised requests, remote, local and forced change, events
//
// Behaviour
// R1: bank one held by coil status; once dropped, bank two takes over.
// R2: selection stays after a request ends; bank one returns only on request.
// R3: bank two held with temporary bank one request returns to bank two.
// R4: request inputs accept any combination of internal signals or digital inputs.
// R5: every change of a monitored condition produces an event of this block.
// R6: per event type, assertion, deassertion or both are stored by configuration.
// R7: each event carries the time stamp of its triggering transition.
// R8: remote change request produces assertion and deassertion events.
// R9: local change request produces assertion and deassertion events.
// R10: request to an unused bank is rejected with failure event, then cleared.
// R11: forced change without force enable is rejected with failure event.
// R12: request refused by higher priority holder raises lower priority failure event.
// R13: per bank enabled, request and active events for all eight banks.
// R14: force enable turning on and off produces events.
// R15: requests rank by index; bank one highest, higher pending wins.
// R16: static held request blocks lower ones; inputs may also be pulsed.
// R17: remote change cannot activate bank below one held by a request signal.
// R18: forced selection overrides requests only while force enable is set.
`timescale 1ns/1ps

module bank_selector_block
(
  input  wire logic                                    clock,
  input  wire logic                                    rst,
  input  wire logic [selector_pkg::NUM_BANKS-1:0]      bank_req,
  input  wire logic [selector_pkg::NUM_BANKS-1:0]      used_banks,
  input  wire logic [selector_pkg::BANK_IDX_W-1:0]     remote_bank,
  input  wire logic                                    local_strobe,
  input  wire logic [selector_pkg::BANK_IDX_W-1:0]     local_bank,
  input  wire logic                                    force_enable,
  input  wire logic [selector_pkg::BANK_IDX_W-1:0]     force_bank,
  input  wire selector_pkg::mode_type [selector_pkg::COND_W-1:0] event_mode,
  output logic      [selector_pkg::NUM_BANKS-1:0]      active_bank,
  output selector_pkg::event_type                      event_out
);
  import selector_pkg::*;

  logic [NUM_BANKS-1:0]  active_ff, nxt_active;
  logic [BANK_IDX_W-1:0] remote_prev_ff, nxt_remote_prev;
  logic [BANK_IDX_W-1:0] force_prev_ff, nxt_force_prev;
  logic [NUM_BANKS-1:0]  req_prev_ff, nxt_req_prev;
  logic                  fail_notcfg_ff, nxt_fail_notcfg;
  logic                  fail_force_ff, nxt_fail_force;
  logic                  fail_low_ff, nxt_fail_low;
  logic [COND_W-1:0]     cond_ff, nxt_cond;
  logic                  primed_ff, nxt_primed;
  logic [STAMP_W-1:0]    time_ff, nxt_time;
  event_type             ev_ff, nxt_ev;

  logic [NUM_BANKS-1:0]  used_eff;
  logic                  held_any, held_any_prev, held_edge;
  logic [2:0]            held_idx, held_idx_prev;
  logic                  rem_new, loc_new, force_new, forcing;
  logic [2:0]            rem_idx, loc_idx, force_idx;
  logic [COND_W-1:0]     cond_now;
  // per bit results kept apart so the event word has a single writer
  logic [COND_W-1:0]     ev_on_bits;
  logic [COND_W-1:0]     ev_off_bits;

  // lowest set bit wins: bank one has the highest priority
  function automatic logic [2:0] top_bank(input logic [NUM_BANKS-1:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_BANKS - 1; i >= 0; i--)
    begin
      if (req[i])
        idx = 3'(i);
    end
    return idx;
  endfunction : top_bank

  function automatic logic [NUM_BANKS-1:0] onehot(input logic [2:0] idx);
    return NUM_BANKS'(1) << idx;
  endfunction : onehot

  // request events are derived from these inputs, combined outside the block [R4]
  always_comb
  begin
    used_eff = used_banks | BANK_ONE_MASK;
    held_any = |bank_req;
    held_idx = top_bank(bank_req);
    held_any_prev = |req_prev_ff;
    held_idx_prev = top_bank(req_prev_ff);
    // pulses and fresh holders both show as a change of the top request [R16]
    held_edge = held_any && (!held_any_prev || held_idx != held_idx_prev);
    rem_idx = 3'(remote_bank - 4'h1);
    loc_idx = 3'(local_bank - 4'h1);
    force_idx = 3'(force_bank - 4'h1);
    rem_new = (remote_bank != BANK_NONE) && (remote_bank != remote_prev_ff);
    loc_new = local_strobe && (local_bank != BANK_NONE);
    force_new = (force_bank != BANK_NONE) && (force_bank != force_prev_ff);
    forcing = force_enable && (force_bank != BANK_NONE);
  end

  // bank selection and rejection
  always_comb
  begin
    nxt_active = active_ff;
    nxt_fail_notcfg = 1'b0;
    nxt_fail_force = 1'b0;
    nxt_fail_low = 1'b0;
    nxt_req_prev = bank_req;
    nxt_remote_prev = remote_bank;
    nxt_force_prev = force_bank;
    if (force_new && !force_enable)
      nxt_fail_force = 1'b1; // [R11]
    if (forcing)
    begin
      // force wins over every request while enabled with a force bank given [R18]
      if (used_eff[force_idx])
        nxt_active = onehot(force_idx);
      else if (force_new)
        nxt_fail_notcfg = 1'b1; // [R10]
      if (rem_new || loc_new)
        nxt_fail_low = 1'b1;
    end
    else if (held_edge)
    begin
      // top held request decides; bank two returns when bank one drops [R1] [R3] [R15]
      if (used_eff[held_idx])
        nxt_active = onehot(held_idx);
      else
        nxt_fail_notcfg = 1'b1; // [R10]
      if ((rem_new && rem_idx >= held_idx) || (loc_new && loc_idx >= held_idx))
        nxt_fail_low = 1'b1; // [R12]
    end
    else if (rem_new || loc_new)
    begin
      // a held input blocks requests of equal or lower priority [R16] [R17]
      if (held_any && ((rem_new && rem_idx >= held_idx) ||
                       (loc_new && loc_idx >= held_idx)))
        nxt_fail_low = 1'b1; // [R12]
      else if (rem_new && used_eff[rem_idx])
        nxt_active = onehot(rem_idx);
      else if (!rem_new && used_eff[loc_idx])
        nxt_active = onehot(loc_idx);
      else
        nxt_fail_notcfg = 1'b1; // [R10]
    end
    // otherwise the last selection simply stays [R2]
  end

  // monitored conditions; a failure level lasts one cycle, or as long as a refused local_strobe stays set, giving on then off [R5] [R13]
  always_comb
  begin
    cond_now = '0;
    cond_now[COND_ENABLED +: NUM_BANKS] = used_eff;
    cond_now[COND_REQUEST +: NUM_BANKS] = bank_req;
    cond_now[COND_ACTIVE +: NUM_BANKS] = active_ff;
    cond_now[COND_REMOTE] = remote_bank != BANK_NONE; // [R8]
    cond_now[COND_LOCAL] = local_strobe; // [R9]
    cond_now[COND_FORCE] = force_enable; // [R14]
    cond_now[COND_FAIL_NOTCFG] = fail_notcfg_ff;
    cond_now[COND_FAIL_FORCE] = fail_force_ff;
    cond_now[COND_FAIL_LOWPRIO] = fail_low_ff;
    nxt_cond = cond_now;
    nxt_primed = 1'b1;
    nxt_time = time_ff + STAMP_W'(1);
  end

  // per event filtering; the first cycle after reset only primes the history
  generate
    for (genvar g = 0; g < COND_W; g++)
    begin : g_event
      assign ev_on_bits[g] = primed_ff && cond_now[g] && !cond_ff[g] &&
                             event_mode[g][MODE_ON_BIT]; // [R6]
      assign ev_off_bits[g] = primed_ff && !cond_now[g] && cond_ff[g] &&
                              event_mode[g][MODE_OFF_BIT]; // [R6]
    end
  endgenerate

  // every change seen in one cycle shares that cycle's stamp [R7]
  always_comb
  begin
    nxt_ev.on = ev_on_bits;
    nxt_ev.off = ev_off_bits;
    nxt_ev.valid = |ev_on_bits || |ev_off_bits;
    nxt_ev.stamp = time_ff;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      active_ff <= RESET_ACTIVE;
      remote_prev_ff <= BANK_NONE;
      force_prev_ff <= BANK_NONE;
      req_prev_ff <= '0;
      fail_notcfg_ff <= 1'b0;
      fail_force_ff <= 1'b0;
      fail_low_ff <= 1'b0;
    end
    else
    begin
      active_ff <= nxt_active;
      remote_prev_ff <= nxt_remote_prev;
      force_prev_ff <= nxt_force_prev;
      req_prev_ff <= nxt_req_prev;
      fail_notcfg_ff <= nxt_fail_notcfg;
      fail_force_ff <= nxt_fail_force;
      fail_low_ff <= nxt_fail_low;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cond_ff <= '0;
      primed_ff <= 1'b0;
      time_ff <= RESET_STAMP;
      ev_ff <= '0;
    end
    else
    begin
      cond_ff <= nxt_cond;
      primed_ff <= nxt_primed;
      time_ff <= nxt_time;
      ev_ff <= nxt_ev;
    end
  end

  assign active_bank = active_ff;
  assign event_out = ev_ff;

  // checks
  sequence s_two_held_one_pulse;
    bank_req == 8'h03 && !force_enable ##1 bank_req == 8'h02 && !force_enable;
  endsequence

  sequence s_fail_blip(logic f);
    f ##1 !f;
  endsequence

  chk_reset_bank_one: assert property (@(posedge clock) // [R2]
    $past(rst) && !rst |-> active_ff == RESET_ACTIVE)
    else $error("bank one not active after reset");

  chk_held_select: assert property (@(posedge clock) disable iff (rst) // [R15]
    held_edge && !forcing && used_eff[held_idx] |=> active_ff == onehot($past(held_idx)))
    else $error("held request did not select its bank");

  chk_keep_idle: assert property (@(posedge clock) disable iff (rst) // [R2]
    !held_edge && !forcing && !rem_new && !loc_new |=> $stable(active_ff))
    else $error("selection changed without a request");

  chk_return_two: assert property (@(posedge clock) disable iff (rst) // [R3]
    s_two_held_one_pulse ##0 used_eff[1] |=> active_ff == 8'h02)
    else $error("bank two not restored after bank one request");

  chk_coil_drop: assert property (@(posedge clock) disable iff (rst) // [R1]
    $fell(bank_req[0]) && bank_req == 8'h02 && !force_enable && used_eff[1]
      |=> active_ff == 8'h02)
    else $error("bank two not taken after coil status dropped");

  chk_unused_reject: assert property (@(posedge clock) disable iff (rst) // [R10]
    !forcing && held_edge && !used_eff[held_idx] |=> $stable(active_ff) ##0
      s_fail_blip(fail_notcfg_ff))
    else $error("unused bank request not rejected");

  chk_force_fail: assert property (@(posedge clock) disable iff (rst) // [R11]
    force_new && !force_enable |=> fail_force_ff)
    else $error("force without enable not flagged");

  chk_low_refused: assert property (@(posedge clock) disable iff (rst) // [R17]
    !forcing && !held_edge && held_any && rem_new && rem_idx > held_idx
      |=> fail_low_ff && $stable(active_ff))
    else $error("lower priority remote request not refused");

  chk_force_wins: assert property (@(posedge clock) disable iff (rst) // [R18]
    forcing && used_eff[force_idx] |=> active_ff == onehot($past(force_idx)))
    else $error("forced bank not applied");

  chk_event_stamp: assert property (@(posedge clock) disable iff (rst) // [R7]
    ev_ff.valid |-> ev_ff.stamp == time_ff - STAMP_W'(1))
    else $error("event stamp not from its transition cycle");

  chk_remote_event: assert property (@(posedge clock) disable iff (rst) // [R8]
    primed_ff && $past(primed_ff) && $rose(remote_bank != BANK_NONE) &&
      event_mode[COND_REMOTE][MODE_ON_BIT] |=> ev_ff.on[COND_REMOTE])
    else $error("remote request event missing");

  chk_mode_filter: assert property (@(posedge clock) disable iff (rst) // [R6]
    ev_ff.on[COND_FORCE] |-> $past(event_mode[COND_FORCE][MODE_ON_BIT]))
    else $error("event stored against its storage choice");

  chk_local_select: assert property (@(posedge clock) disable iff (rst) // [R9]
    !forcing && !held_edge && !held_any && !rem_new && loc_new && used_eff[loc_idx]
      |=> active_ff == onehot($past(loc_idx)))
    else $error("local request did not select its bank");

  // the fail level is registered, so its event trails the refusal by one more cycle
  chk_lowprio_event: assert property (@(posedge clock) disable iff (rst) // [R12]
    primed_ff && fail_low_ff && !cond_ff[COND_FAIL_LOWPRIO] &&
      event_mode[COND_FAIL_LOWPRIO][MODE_ON_BIT] |=> ev_ff.on[COND_FAIL_LOWPRIO])
    else $error("lower priority failure event missing");

endmodule : bank_selector_block

// [bank_selector_block_test.sv]
// self-checking bench for the parameter bank selector
`timescale 1ns/1ps

module bank_selector_block_test;
  import selector_pkg::*;

  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  logic                  coil_in_use = 1'b0;
  logic                  coil_closed = 1'b0;
  logic                  wire_intact = 1'b1;
  logic [NUM_BANKS-1:0]  extra_req = 8'h00;
  logic [NUM_BANKS-1:0]  bank_req;
  logic [NUM_BANKS-1:0]  used_banks = 8'hff;
  logic [BANK_IDX_W-1:0] remote_bank = 4'h0;
  logic [BANK_IDX_W-1:0] local_bank = 4'h0;
  logic [BANK_IDX_W-1:0] force_bank = 4'h0;
  logic                  local_strobe = 1'b0;
  logic                  force_enable = 1'b0;
  mode_type [COND_W-1:0] event_mode = {COND_W{2'h3}};
  logic [NUM_BANKS-1:0]  active_bank;
  event_type             event_out;
  logic                  on_hit;
  logic                  off_hit;
  logic [STAMP_W-1:0]    on_st;
  logic [STAMP_W-1:0]    off_st;
  int                    bad_count = 0;
  int                    comparisons = 0;

  always #12.5 clock = ~clock;

  request_source src (.coil_in_use(coil_in_use), .coil_closed(coil_closed),
    .wire_intact(wire_intact), .extra_req(extra_req), .bank_req(bank_req));

  bank_selector_block dut (.clock(clock), .rst(rst), .bank_req(bank_req),
    .used_banks(used_banks), .remote_bank(remote_bank), .local_strobe(local_strobe),
    .local_bank(local_bank), .force_enable(force_enable), .force_bank(force_bank),
    .event_mode(event_mode), .active_bank(active_bank), .event_out(event_out));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : cycles

  // scans six settled cycles for the on and off event of one condition
  task automatic ev(input int idx);
    on_hit = 1'b0;
    off_hit = 1'b0;
    repeat (6)
    begin
      @(negedge clock);
      if (event_out.valid === 1'b1 && event_out.on[idx] === 1'b1)
      begin
        on_hit = 1'b1;
        on_st = event_out.stamp;
      end
      if (event_out.valid === 1'b1 && event_out.off[idx] === 1'b1)
      begin
        off_hit = 1'b1;
        off_st = event_out.stamp;
      end
    end
    @(posedge clock);
  endtask : ev

  task automatic t_coil;
    coil_in_use <= 1'b1;
    coil_closed <= 1'b1;
    cycles(3);
    check(active_bank, 8'h01);
    coil_closed <= 1'b0;
    ev(COND_REQUEST + 1);
    check(on_hit, 1'b1);
    check(active_bank, 8'h02);
    coil_closed <= 1'b1;
    cycles(3);
    wire_intact <= 1'b0;
    cycles(3);
    check(active_bank, 8'h02);
    coil_in_use <= 1'b0;
    wire_intact <= 1'b1;
    cycles(3);
  endtask : t_coil

  task automatic t_prio;
    extra_req <= 8'h02;
    cycles(3);
    extra_req <= 8'h03;
    cycles(3);
    check(active_bank, 8'h01);
    extra_req <= 8'h02;
    cycles(3);
    check(active_bank, 8'h02);
    extra_req <= 8'h00;
    cycles(3);
    check(active_bank, 8'h02);
    extra_req <= 8'h04;
    cycles(1);
    extra_req <= 8'h00;
    cycles(3);
    check(active_bank, 8'h04);
  endtask : t_prio

  task automatic t_remote;
    event_mode[COND_REMOTE] <= 2'h1;
    remote_bank <= 4'h6;
    ev(COND_REMOTE);
    check(on_hit, 1'b1);
    check(active_bank, 8'h20);
    remote_bank <= 4'h0;
    ev(COND_REMOTE);
    check(off_hit, 1'b0);
    event_mode[COND_REMOTE] <= 2'h3;
    extra_req <= 8'h02;
    cycles(3);
    remote_bank <= 4'h5;
    ev(COND_FAIL_LOWPRIO);
    check({on_hit, off_hit}, 2'h3);
    check(active_bank, 8'h02);
    remote_bank <= 4'h0;
    extra_req <= 8'h00;
    used_banks <= 8'h0f;
    cycles(2);
    remote_bank <= 4'h7;
    ev(COND_FAIL_NOTCFG);
    check({on_hit, off_hit}, 2'h3);
    check(off_st - on_st, 32'h1);
    check(active_bank, 8'h02);
    remote_bank <= 4'h0;
    extra_req <= 8'h10;
    ev(COND_FAIL_NOTCFG);
    check({on_hit, off_hit}, 2'h3);
    check(active_bank, 8'h02);
    extra_req <= 8'h00;
    used_banks <= 8'hff;
  endtask : t_remote

  task automatic t_local_force;
    local_bank <= 4'h3;
    local_strobe <= 1'b1;
    ev(COND_LOCAL);
    check(on_hit, 1'b1);
    check(active_bank, 8'h04);
    local_strobe <= 1'b0;
    ev(COND_LOCAL);
    check(off_hit, 1'b1);
    force_bank <= 4'h5;
    ev(COND_FAIL_FORCE);
    check({on_hit, off_hit}, 2'h3);
    check(active_bank, 8'h04);
    force_bank <= 4'h0;
    force_enable <= 1'b1;
    ev(COND_FORCE);
    check(on_hit, 1'b1);
    force_bank <= 4'h5;
    extra_req <= 8'h01;
    cycles(3);
    check(active_bank, 8'h10);
    force_enable <= 1'b0;
    ev(COND_FORCE);
    check(off_hit, 1'b1);
    extra_req <= 8'h00;
    cycles(2);
    extra_req <= 8'h01;
    cycles(3);
    check(active_bank, 8'h01);
  endtask : t_local_force

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial
  begin
    cycles(6);
    rst <= 1'b0;
    cycles(3);
    check(active_bank, 8'h01);
    t_coil();
    t_prio();
    t_remote();
    t_local_force();
    results();
  end

  // whole sequence needs about 120 cycles
  initial
  begin
    cycles(2000);
    bad_count++;
    results();
  end
endmodule : bank_selector_block_test

// [request_source.sv]
// request source model: coil status wiring plus logic-built bank requests
`timescale 1ns/1ps

module request_source
(
  input  wire logic                           coil_in_use,
  input  wire logic                           coil_closed,
  input  wire logic                           wire_intact,
  input  wire logic [selector_pkg::NUM_BANKS-1:0] extra_req,
  output logic      [selector_pkg::NUM_BANKS-1:0] bank_req
);
  import selector_pkg::*;

  logic line_level;

  // the status input has a pull-down, so a broken wire reads as an open coil
  assign line_level = coil_closed & wire_intact;
  // inverted copy feeds bank two so any loss of the line lands on bank two
  assign bank_req = extra_req | (coil_in_use ? {6'h00, ~line_level, line_level} : 8'h00);
endmodule : request_source

// [selector_pkg.sv]
// constants and carrier types for the parameter bank selector
package selector_pkg;

  localparam int NUM_BANKS = 8;
  localparam int BANK_IDX_W = 4;
  localparam int STAMP_W = 32;

  // event condition positions inside the monitored condition vector
  localparam int COND_ENABLED = 0;
  localparam int COND_REQUEST = 8;
  localparam int COND_ACTIVE = 16;
  localparam int COND_REMOTE = 24;
  localparam int COND_LOCAL = 25;
  localparam int COND_FORCE = 26;
  localparam int COND_FAIL_NOTCFG = 27;
  localparam int COND_FAIL_FORCE = 28;
  localparam int COND_FAIL_LOWPRIO = 29;
  localparam int COND_W = 30;

  // bank number 0 means no bank requested
  localparam logic [BANK_IDX_W-1:0] BANK_NONE = 4'h0;
  // parameter_bank_one is active after reset and is always a used bank
  localparam logic [NUM_BANKS-1:0] BANK_ONE_MASK = 8'h01;
  localparam logic [NUM_BANKS-1:0] RESET_ACTIVE = 8'h01;
  localparam logic [STAMP_W-1:0] RESET_STAMP = 32'h0000_0000;

  // per event type storage choice: bit 0 keeps assertion, bit 1 keeps deassertion
  localparam int MODE_ON_BIT = 0;
  localparam int MODE_OFF_BIT = 1;

  typedef logic [1:0] mode_type;

  typedef struct packed {
    logic                 valid;
    logic [COND_W-1:0]    on;
    logic [COND_W-1:0]    off;
    logic [STAMP_W-1:0]   stamp;
  } event_type;

endpackage : selector_pkg
